// ---- core/timer8_params.svh ----
// Purpose: constants for the 8-bit timer waveform mode control block
// Assumes: 8-bit register port, one clock, synchronous reset
// Notes: offsets are word indices on the plain register port
//
// What this block does
// - every flop runs on the one clock and the timer tick only qualifies counting, matches, pwm top actions, flags and pwm compare loads.
// - a nonzero action field hands the pin to the compare output, except 01 in pwm unless output A has the high mode bit; driven only when direction is out.
// - in normal and clear-on-match modes output A does nothing, toggles, clears or sets on match.
// - in fast pwm output A toggles for 01 only with the high mode bit, 10 clears/sets at top, 11 inverts.
// - in phase pwm output A 10 clears up and sets down, 11 inverts, 01 as in fast pwm.
// - in pwm a compare equal to top with upper action bit set is ignored but top still sets or clears.
// - in normal and clear-on-match modes output B does nothing, toggles, clears or sets on match.
// - in fast pwm output B 01 has no toggle, 10 clears on match and sets at top, 11 inverts.
// - in phase pwm output B 01 has no toggle, 10 clears up and sets down, 11 inverts.
// - bits 3 and 2 of the first control register always read as zero.
// - the 3-bit mode is two low bits of control A and one high bit of control B, decoded per mode table.
// - top is 0xFF in modes 0, 1, 3 and the active compare A value in modes 2, 5, 7.
// - overflow is set at MAX in modes 0, 2, 3, at bottom in modes 1, 5 and at top in mode 7.
// - in clear-on-match and fast pwm mode 7 reaching compare A sets its flag and clears the counter.
// - clock select stops, divides by 1, 8, 64, 256, 1024 or takes the pin's falling or rising edge.
`ifndef TIMER8_PARAMS_SVH
`define TIMER8_PARAMS_SVH

// ========================================
// register offsets
`define OFS_CTRL_A 4'h0
`define OFS_CTRL_B 4'h1
`define OFS_COUNT 4'h2
`define OFS_CMP_A 4'h3
`define OFS_CMP_B 4'h4
`define OFS_STATUS 4'h5
`define OFS_IRQ_CLR 4'h6
`define OFS_IRQ_EN 4'h7

// ========================================
// field positions and reset values
`define CTRL_A_RD_MASK 8'hF3
`define CTRL_B_RD_MASK 8'h0F
`define HIGH_BIT_POS 3
`define RST_BYTE 8'h00
`define RST_FLAGS 3'h0
`define FLAG_OVF 0
`define FLAG_CMP_A 1
`define FLAG_CMP_B 2

// ========================================
// counter limits and mode codes
`define CNT_MAX 8'hFF
`define CNT_BOTTOM 8'h00
`define MODE_NORMAL 3'h0
`define MODE_PHASE_FF 3'h1
`define MODE_CTC 3'h2
`define MODE_FAST_FF 3'h3
`define MODE_PHASE_A 3'h5
`define MODE_FAST_A 3'h7

// ========================================
// clock select codes
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

`endif

// ---- core/timer8_pkg.sv ----
// Purpose: shared types of the timer waveform block
// Assumes: constants live in timer8_params.svh
// Notes: kinds are one-hot
package timer8_pkg;

  // ========================================
  // register port request
  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // ordinary port logic for one pin
  typedef struct packed
  {
    logic dout;
    logic dir;
  } pin_port_t;

  // counting behaviour of the decoded mode
  typedef enum logic [3:0]
  {
    KIND_NORMAL = 4'h1,
    KIND_CTC = 4'h2,
    KIND_FAST = 4'h4,
    KIND_PHASE = 4'h8
  } wave_kind_t;

endpackage

// ---- core/timer8_prescaler.sv ----
// Purpose: timer tick enable from clock select
// Assumes: ext_clk_pin is asynchronous to clk
// Notes: prescaler runs free, so the first divided tick may come early
`timescale 1ns/1ps
`include "timer8_params.svh"

module timer8_prescaler
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] clock_source_sel,
  input wire logic ext_clk_pin,
  output logic tick
);
  import timer8_pkg::*;

  logic [9:0] pre_cnt_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;
  logic tick_nxt;

  // ========================================
  // free running divider
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pre_cnt_r <= 10'h000;
    else
      pre_cnt_r <= pre_cnt_r + 10'h001;
  end

  // two-flop synchroniser, third flop for the edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= ext_clk_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // tap select
  always_comb
  begin
    case (clock_source_sel)
      `CS_STOP: tick_nxt = 1'b0;
      `CS_DIV1: tick_nxt = 1'b1;
      `CS_DIV8: tick_nxt = &pre_cnt_r[2:0];
      `CS_DIV64: tick_nxt = &pre_cnt_r[5:0];
      `CS_DIV256: tick_nxt = &pre_cnt_r[7:0];
      `CS_DIV1024: tick_nxt = &pre_cnt_r[9:0];
      `CS_EXT_FALL: tick_nxt = pin_s3_r & ~pin_s2_r;
      `CS_EXT_RISE: tick_nxt = ~pin_s3_r & pin_s2_r;
      default: tick_nxt = 1'b0;
    endcase
  end

  // registered so the tick is a clean one-cycle enable
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tick <= 1'b0;
    else
      tick <= tick_nxt;
  end

endmodule

// ---- core/timer8_waveform_mode_control.sv ----
// Purpose: 8-bit timer with waveform modes and two compare outputs
// Assumes: pin port logic is on clk; ext clock pin is asynchronous
// Notes: pins and oe lag internal state by one cycle
`timescale 1ns/1ps
`include "timer8_params.svh"

module timer8_waveform_mode_control
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire timer8_pkg::bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire logic ext_clk_pin,
  input wire timer8_pkg::pin_port_t port_a,
  input wire timer8_pkg::pin_port_t port_b,
  output logic cmp_out_a,
  output logic cmp_out_a_oe_n,
  output logic cmp_out_b,
  output logic cmp_out_b_oe_n,
  output logic irq
);
  import timer8_pkg::*;

  // ========================================
  // declarations
  logic [7:0] ctrl_a_r;
  logic [3:0] ctrl_b_r;
  logic [7:0] count_r;
  logic count_down_r;
  logic block_r;
  logic [2:0] flags_r;
  logic [2:0] irq_en_r;
  logic [7:0] rd_data_r;
  logic irq_r;
  logic timer_tick_enable;
  logic [2:0] wave_mode_sel;
  logic [2:0] clock_source_sel;
  logic wave_mode_high_bit;
  logic [1:0] out_a_action;
  logic [1:0] out_b_action;
  wave_kind_t kind;
  logic pwm;
  logic [7:0] top_val;
  logic at_top;
  logic at_max;
  logic at_bottom;
  logic ovf_hit;
  logic cmp_upd;
  logic [1:0] match_hit;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic [1:0] act_arr [2];
  logic [7:0] cmp_act_a;
  logic [7:0] cmp_buf_a;
  logic [7:0] cmp_buf_b;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_count;
  logic wr_clr;
  logic wr_en;

  // ========================================
  // field views
  assign out_a_action = ctrl_a_r[7:6];
  assign out_b_action = ctrl_a_r[5:4];
  assign wave_mode_high_bit = ctrl_b_r[`HIGH_BIT_POS];
  assign wave_mode_sel = {wave_mode_high_bit, ctrl_a_r[1:0]};
  assign clock_source_sel = ctrl_b_r[2:0];
  assign act_arr[0] = out_a_action;
  assign act_arr[1] = out_b_action;

  // write strobes per register
  assign wr_ctrl_a = bus_req.wr & (bus_req.addr == `OFS_CTRL_A);
  assign wr_ctrl_b = bus_req.wr & (bus_req.addr == `OFS_CTRL_B);
  assign wr_count = bus_req.wr & (bus_req.addr == `OFS_COUNT);
  assign wr_clr = bus_req.wr & (bus_req.addr == `OFS_IRQ_CLR);
  assign wr_en = bus_req.wr & (bus_req.addr == `OFS_IRQ_EN);

  // ========================================
  // tick source
  timer8_prescaler u_prescaler
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .clock_source_sel(clock_source_sel),
    .ext_clk_pin(ext_clk_pin),
    .tick(timer_tick_enable)
  );

  // ========================================
  // mode decode; reserved modes count as normal with no top reload
  always_comb
  begin
    case (wave_mode_sel)
      `MODE_NORMAL: kind = KIND_NORMAL;
      `MODE_CTC: kind = KIND_CTC;
      `MODE_FAST_FF: kind = KIND_FAST;
      `MODE_FAST_A: kind = KIND_FAST;
      `MODE_PHASE_FF: kind = KIND_PHASE;
      `MODE_PHASE_A: kind = KIND_PHASE;
      default: kind = KIND_NORMAL;
    endcase
  end

  assign pwm = (kind == KIND_FAST) | (kind == KIND_PHASE);

  // top from compare A only in the three reloadable modes
  assign top_val = ((wave_mode_sel == `MODE_CTC) |
                    (wave_mode_sel == `MODE_PHASE_A) |
                    (wave_mode_sel == `MODE_FAST_A)) ? cmp_act_a : `CNT_MAX;
  assign at_top = (count_r == top_val);
  assign at_max = (count_r == `CNT_MAX);
  assign at_bottom = (count_r == `CNT_BOTTOM);

  // ========================================
  // control registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ctrl_a_r <= `RST_BYTE;
    else if (wr_ctrl_a)
      ctrl_a_r <= bus_req.wdata & `CTRL_A_RD_MASK;
  end

  // force strobes are not kept, so they read as zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ctrl_b_r <= 4'h0;
    else if (wr_ctrl_b)
      ctrl_b_r <= bus_req.wdata[3:0];
  end

  // ========================================
  // counter and direction
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count_r <= `CNT_BOTTOM;
      count_down_r <= 1'b0;
    end
    else if (wr_count)
    begin
      count_r <= bus_req.wdata;
      count_down_r <= count_down_r;
    end
    else if (kind != KIND_PHASE)
    begin
      count_down_r <= 1'b0;
      if (timer_tick_enable)
      begin
        if ((kind == KIND_CTC) | (kind == KIND_FAST))
          count_r <= at_top ? `CNT_BOTTOM : count_r + 8'h01;
        else
          count_r <= count_r + 8'h01;
      end
    end
    else if (timer_tick_enable)
    begin
      // dual slope: top and bottom each last one tick
      if (count_down_r)
      begin
        if (at_bottom)
        begin
          count_down_r <= 1'b0;
          count_r <= count_r + 8'h01;
        end
        else
          count_r <= count_r - 8'h01;
      end
      else if (at_top)
      begin
        count_down_r <= 1'b1;
        count_r <= at_bottom ? `CNT_BOTTOM : count_r - 8'h01;
      end
      else
        count_r <= count_r + 8'h01;
    end
  end

  // a count write blocks the match on the next tick
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      block_r <= 1'b0;
    else if (wr_count)
      block_r <= 1'b1;
    else if (timer_tick_enable)
      block_r <= 1'b0;
  end

  // ========================================
  // overflow condition per mode
  always_comb
  begin
    case (kind)
      KIND_PHASE: ovf_hit = at_bottom & count_down_r;
      KIND_FAST: ovf_hit = (wave_mode_sel == `MODE_FAST_A) ? at_top : at_max;
      default: ovf_hit = at_max;
    endcase
  end

  // buffered compare values load at top in pwm modes
  assign cmp_upd = pwm & timer_tick_enable & at_top;

  // ========================================
  // compare channels
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : ch_g
      logic [7:0] buf_r;
      logic [7:0] act_r;
      logic oc_r;
      logic pin_r;
      logic oe_n_r;
      logic wr_cmp;
      logic ignore;
      logic hit;
      logic tgl_ok;
      logic own_pin;
      logic [1:0] act;
      logic oc_nxt;
      pin_port_t port;

      assign act = act_arr[ch];
      assign port = (ch == 0) ? port_a : port_b;
      assign wr_cmp = bus_req.wr &
                      (bus_req.addr == ((ch == 0) ? `OFS_CMP_A : `OFS_CMP_B));
      // only output A toggles in pwm, and only with the high mode bit
      assign tgl_ok = (ch == 0) & wave_mode_high_bit;
      assign ignore = pwm & (act_r == top_val) & act[1];
      assign hit = timer_tick_enable & ~block_r & (count_r == act_r);
      assign match_hit[ch] = hit;
      // A with 01 in pwm without the high bit stays with the port
      assign own_pin = (act != 2'b00) &
                       ~(pwm & (act == 2'b01) & ~tgl_ok);

      // software copy of the compare value
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          buf_r <= `RST_BYTE;
        else if (wr_cmp)
          buf_r <= bus_req.wdata;
      end

      // active compare value
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          act_r <= `RST_BYTE;
        else if (!pwm)
          act_r <= wr_cmp ? bus_req.wdata : buf_r;
        else if (cmp_upd)
          act_r <= buf_r;
      end

      // output action on match and at top
      always_comb
      begin
        oc_nxt = oc_r;
        if (!pwm)
        begin
          if (hit)
          begin
            case (act)
              2'b01: oc_nxt = ~oc_r;
              2'b10: oc_nxt = 1'b0;
              2'b11: oc_nxt = 1'b1;
              default: oc_nxt = oc_r;
            endcase
          end
        end
        else
        begin
          if (hit & ~ignore)
          begin
            case (act)
              2'b01: oc_nxt = tgl_ok ? ~oc_r : oc_r;
              2'b10: oc_nxt = (kind == KIND_PHASE) & count_down_r;
              2'b11: oc_nxt = ~((kind == KIND_PHASE) & count_down_r);
              default: oc_nxt = oc_r;
            endcase
          end
          // fast pwm always acts at top; phase pwm only for the ignored match
          if (timer_tick_enable & at_top & ((kind == KIND_FAST) | ignore))
          begin
            case (act)
              2'b10: oc_nxt = 1'b1;
              2'b11: oc_nxt = 1'b0;
              default: oc_nxt = oc_nxt;
            endcase
          end
        end
      end

      // compare output state
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          oc_r <= 1'b0;
        else
          oc_r <= oc_nxt;
      end

      // pin mux; driver follows the port direction either way
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          pin_r <= 1'b0;
          oe_n_r <= 1'b1;
        end
        else
        begin
          pin_r <= own_pin ? oc_r : port.dout;
          oe_n_r <= ~port.dir;
        end
      end
    end
  endgenerate

  assign cmp_act_a = ch_g[0].act_r;
  assign cmp_buf_a = ch_g[0].buf_r;
  assign cmp_buf_b = ch_g[1].buf_r;

  // ========================================
  // sticky flags: a set in the clear cycle wins
  assign flag_set[`FLAG_OVF] = timer_tick_enable & ovf_hit;
  assign flag_set[`FLAG_CMP_A] = match_hit[0];
  assign flag_set[`FLAG_CMP_B] = match_hit[1];
  assign flag_clr = wr_clr ? bus_req.wdata[2:0] : 3'h0;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      flags_r <= `RST_FLAGS;
    else
      flags_r <= (flags_r & ~flag_clr) | flag_set;
  end

  // interrupt enables
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_en_r <= `RST_FLAGS;
    else if (wr_en)
      irq_en_r <= bus_req.wdata[2:0];
  end

  // level interrupt, one cycle behind the flags
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_r <= 1'b0;
    else
      irq_r <= |(flags_r & irq_en_r);
  end

  // ========================================
  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rd_data_r <= `RST_BYTE;
    else if (bus_req.rd)
    begin
      case (bus_req.addr)
        `OFS_CTRL_A: rd_data_r <= ctrl_a_r & `CTRL_A_RD_MASK;
        `OFS_CTRL_B: rd_data_r <= {4'h0, ctrl_b_r};
        `OFS_COUNT: rd_data_r <= count_r;
        `OFS_CMP_A: rd_data_r <= cmp_buf_a;
        `OFS_CMP_B: rd_data_r <= cmp_buf_b;
        `OFS_STATUS: rd_data_r <= {5'h00, flags_r};
        `OFS_IRQ_EN: rd_data_r <= {5'h00, irq_en_r};
        default: rd_data_r <= `RST_BYTE;
      endcase
    end
    else
      rd_data_r <= `RST_BYTE;
  end

  // ========================================
  // outputs
  assign rd_data = rd_data_r;
  assign irq = irq_r;
  assign cmp_out_a = ch_g[0].pin_r;
  assign cmp_out_a_oe_n = ch_g[0].oe_n_r;
  assign cmp_out_b = ch_g[1].pin_r;
  assign cmp_out_b_oe_n = ch_g[1].oe_n_r;

endmodule

// ---- verif/timer8_wmc_sva.sv ----
// Purpose: port-level checks for the timer waveform block
// Assumes: one clock, synchronous active-high reset
// Notes: keeps a shadow of control A to predict readback and pin ownership
`timescale 1ns/1ps

module timer8_wmc_checker
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire timer8_pkg::bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic ext_clk_pin,
  input wire timer8_pkg::pin_port_t port_a,
  input wire timer8_pkg::pin_port_t port_b,
  input wire logic cmp_out_a,
  input wire logic cmp_out_a_oe_n,
  input wire logic cmp_out_b,
  input wire logic cmp_out_b_oe_n,
  input wire logic irq
);
  import timer8_pkg::*;
  logic [7:0] ctl_a_r;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ========================================
  // shadow of control A, written only through the bus
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ctl_a_r <= 8'h00;
    else if (bus_req.wr && bus_req.addr == 4'h0)
      ctl_a_r <= bus_req.wdata;
  end

  sequence s_rd_ctl_a;
    bus_req.rd && bus_req.addr == 4'h0;
  endsequence

  // disabling every source must drop the line two edges later
  sequence s_wr_en_off;
    bus_req.wr && bus_req.addr == 4'h7 && bus_req.wdata == 8'h00;
  endsequence

  // ========================================
  // bus answers
  a_rd_idle_zero: assert property (!bus_req.rd |=> rd_data == 8'h00)
    else $error("read data not zero outside a read answer");
  a_ctrl_a_rsv: assert property (s_rd_ctl_a |=> rd_data[3:2] == 2'b00)
    else $error("reserved control bits read nonzero");
  a_ctrl_a_back: assert property (s_rd_ctl_a |=> rd_data == (ctl_a_r & 8'hF3))
    else $error("control A readback differs from written value");
  a_clr_rd_zero: assert property (bus_req.rd && bus_req.addr == 4'h6 |=> rd_data == 8'h00)
    else $error("clear register read nonzero");
  a_irq_masked: assert property (s_wr_en_off |-> ##2 !irq)
    else $error("interrupt high with all sources disabled");

  // ========================================
  // pin drive and ownership
  a_oe_a_dir: assert property (!$past(sys_rst) |-> cmp_out_a_oe_n == !$past(port_a.dir))
    else $error("pin A enable does not follow direction");
  a_oe_b_dir: assert property (!$past(sys_rst) |-> cmp_out_b_oe_n == !$past(port_b.dir))
    else $error("pin B enable does not follow direction");
  a_pin_a_port: assert property (ctl_a_r[7:6] == 2'b00 && $past(ctl_a_r[7:6]) == 2'b00
    && !$past(sys_rst) |-> cmp_out_a == $past(port_a.dout))
    else $error("pin A not with port while action is off");
  a_pin_b_port: assert property (ctl_a_r[5:4] == 2'b00 && $past(ctl_a_r[5:4]) == 2'b00
    && !$past(sys_rst) |-> cmp_out_b == $past(port_b.dout))
    else $error("pin B not with port while action is off");
endmodule

// ---- verif/timer8_pin_load.sv ----
// Purpose: board load on one compare output pin
// Assumes: a pull-up on the board side of the pin
// Notes: a released pin reads the pull-up level, never the last driven value
`timescale 1ns/1ps

module timer8_pin_load
(
  input wire logic drv,
  input wire logic drv_oe_n,
  output logic pad
);
  // pin follows the block only while its driver is on
  assign pad = drv_oe_n ? 1'b1 : drv;
endmodule

// ---- verif/tb_timer8_waveform_mode_control.sv ----
// Purpose: self-checking bench for the timer waveform block
// Assumes: 200 MHz clock, register reads answer one cycle after the strobe
// Notes: waits are generous so pin checks sit well clear of match points
`timescale 1ns/1ps
`include "timer8_params.svh"
`define CHK(g, e, m) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("wrong value at %0t: %s", $time, m); \
    end \
  end

module tb_timer8_waveform_mode_control;
  import timer8_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  bus_req_t bus_req = '0;
  logic ext_clk_pin = 1'b0;
  pin_port_t port_a = '0;
  pin_port_t port_b = '0;
  logic [7:0] rd_data;
  logic [7:0] d;
  logic [7:0] c;
  logic oa, oa_n, ob, ob_n, irq, pad_a, pad_b;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  // ========================================
  // clock, design and pin loads
  always #2.5 clk = ~clk;

  timer8_waveform_mode_control u_timer8_waveform_mode_control
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .ext_clk_pin(ext_clk_pin),
    .port_a(port_a),
    .port_b(port_b),
    .cmp_out_a(oa),
    .cmp_out_a_oe_n(oa_n),
    .cmp_out_b(ob),
    .cmp_out_b_oe_n(ob_n),
    .irq(irq)
  );
  timer8_pin_load u_timer8_pin_load_a (.drv(oa), .drv_oe_n(oa_n), .pad(pad_a));
  timer8_pin_load u_timer8_pin_load_b (.drv(ob), .drv_oe_n(ob_n), .pad(pad_b));

  // ========================================
  // bus and helper tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask

  // data sampled mid-cycle, where the answer stands
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    d = rd_data;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rst;
    @(posedge clk);
    sys_rst <= 1'b1;
    port_a <= 2'b01;
    port_b <= 2'b01;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task automatic pins(input logic ea, input logic eb, input string m);
    @(negedge clk);
    `CHK(pad_a, ea, m)
    `CHK(pad_b, eb, m)
  endtask

  // ========================================
  // scenarios
  task automatic t_regs;
    rst();
    rd(`OFS_CTRL_A);
    `CHK(d, `RST_BYTE, "control A reset")
    wr(`OFS_CTRL_A, 8'hFF);
    rd(`OFS_CTRL_A);
    `CHK(d, 8'hF3, "control A reserved bits")
    wr(`OFS_CTRL_B, 8'hFF);
    rd(`OFS_CTRL_B);
    `CHK(d, 8'h0F, "control B high mode bit")
    wr(4'h9, 8'h5A);
    rd(4'h9);
    `CHK(d, 8'h00, "unmapped read")
    rd(`OFS_IRQ_CLR);
    `CHK(d, 8'h00, "clear register read")
    $display("test regs done");
  endtask

  // match at 0x10, one check per period, so each action acts once
  task automatic t_normal;
    rst();
    port_b <= 2'b11;
    wr(`OFS_CMP_A, 8'h10);
    wr(`OFS_CMP_B, 8'h10);
    wr(`OFS_CTRL_B, 8'h01);
    cyc(32);
    pins(1'b0, 1'b1, "port owns pins");
    wr(`OFS_CTRL_A, 8'hF0);
    cyc(254);
    pins(1'b1, 1'b1, "set on match");
    wr(`OFS_CTRL_A, 8'hA0);
    cyc(254);
    pins(1'b0, 1'b0, "clear on match");
    wr(`OFS_CTRL_A, 8'h50);
    cyc(254);
    pins(1'b1, 1'b1, "toggle on match");
    port_a <= 2'b00;
    cyc(3);
    @(negedge clk);
    `CHK(oa_n, 1'b1, "driver off with input direction")
    `CHK(pad_a, 1'b1, "released pin at pull-up level")
    $display("test normal done");
  endtask

  task automatic t_flags;
    rst();
    wr(`OFS_CTRL_B, 8'h01);
    cyc(300);
    wr(`OFS_CTRL_B, 8'h00);
    rd(`OFS_STATUS);
    `CHK(d, 8'h07, "normal mode flags")
    wr(`OFS_IRQ_EN, 8'h01);
    cyc(2);
    @(negedge clk);
    `CHK(irq, 1'b1, "interrupt raised")
    wr(`OFS_IRQ_EN, 8'h00);
    cyc(2);
    @(negedge clk);
    `CHK(irq, 1'b0, "interrupt masked")
    wr(`OFS_IRQ_EN, 8'h07);
    wr(`OFS_IRQ_CLR, 8'h07);
    cyc(2);
    rd(`OFS_STATUS);
    `CHK(d, 8'h00, "flags cleared")
    `CHK(irq, 1'b0, "interrupt cleared")
    $display("test flags done");
  endtask

  // compare A as top: clear-on-match, fast pwm and phase pwm with compare A top
  task automatic t_top;
    logic [7:0] ctl [3] = '{8'h02, 8'h03, 8'h01};
    logic [7:0] clk_sel [3] = '{8'h01, 8'h09, 8'h09};
    logic [7:0] flags [3] = '{8'h06, 8'h07, 8'h07};
    for (int i = 0; i < 3; i++)
    begin
      rst();
      wr(`OFS_CMP_A, 8'h20);
      wr(`OFS_CTRL_A, ctl[i]);
      wr(`OFS_CTRL_B, clk_sel[i]);
      cyc(300);
      rd(`OFS_COUNT);
      `CHK(d <= 8'h20, 1'b1, "count passed compare A top")
      rd(`OFS_STATUS);
      `CHK(d, flags[i], "compare A top flags")
    end
    $display("test top done");
  endtask

  task automatic t_fast;
    rst();
    wr(`OFS_CMP_A, 8'h40);
    wr(`OFS_CMP_B, 8'h40);
    wr(`OFS_COUNT, 8'hF0);
    wr(`OFS_CTRL_A, 8'hB3);
    wr(`OFS_CTRL_B, 8'h01);
    cyc(30);
    pins(1'b1, 1'b0, "fast pwm at top");
    wr(`OFS_CMP_A, 8'h80);
    cyc(64);
    pins(1'b0, 1'b1, "fast pwm match, compare held");
    wr(`OFS_CTRL_A, 8'h43);
    port_a <= 2'b11;
    cyc(3);
    pins(1'b1, 1'b0, "toggle action without high bit leaves pin to port");
    $display("test fast done");
  endtask

  // phase pwm with both compares at top: a taken match there would flip both pins
  task automatic t_edge;
    rst();
    wr(`OFS_CMP_A, 8'hFF);
    wr(`OFS_CMP_B, 8'hFF);
    wr(`OFS_COUNT, 8'hF0);
    wr(`OFS_CTRL_A, 8'hB1);
    wr(`OFS_CTRL_B, 8'h01);
    cyc(20);
    repeat (6)
    begin
      cyc(97);
      pins(1'b1, 1'b0, "compare at top ignored");
    end
    $display("test edge done");
  endtask

  // up to 0xFF from reset, down again, past bottom
  task automatic t_phase;
    rst();
    wr(`OFS_CMP_A, 8'h40);
    wr(`OFS_CMP_B, 8'h40);
    wr(`OFS_CTRL_A, 8'hB1);
    wr(`OFS_CTRL_B, 8'h01);
    cyc(80);
    pins(1'b0, 1'b1, "phase pwm up match");
    cyc(250);
    rd(`OFS_STATUS);
    `CHK(d[0], 1'b0, "no overflow at max")
    cyc(120);
    pins(1'b1, 1'b0, "phase pwm down match");
    cyc(100);
    rd(`OFS_STATUS);
    `CHK(d[0], 1'b1, "overflow at bottom")
    $display("test phase done");
  endtask

  task automatic t_clk;
    rst();
    wr(`OFS_CTRL_B, 8'h02);
    cyc(160);
    wr(`OFS_CTRL_B, 8'h00);
    rd(`OFS_COUNT);
    `CHK(d >= 8'h12 && d <= 8'h16, 1'b1, "divide by 8 rate")
    c = d;
    cyc(40);
    rd(`OFS_COUNT);
    `CHK(d, c, "stopped counter")
    wr(`OFS_COUNT, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      wr(`OFS_CTRL_B, 8'h07 - k[7:0]);
      repeat (5)
      begin
        cyc(8);
        ext_clk_pin <= 1'b1;
        cyc(8);
        ext_clk_pin <= 1'b0;
      end
      cyc(8);
      rd(`OFS_COUNT);
      `CHK(d, 8'h05 * (k[7:0] + 8'h01), "external edges counted")
    end
    $display("test clock done");
  endtask

  // ========================================
  // verdict, hang guard and main sequence
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      $display("wrong value at %0t: run hung", $time);
      print_verdict();
    end
  end

  initial
  begin
    t_regs();
    t_normal();
    t_flags();
    t_top();
    t_fast();
    t_edge();
    t_phase();
    t_clk();
    print_verdict();
  end
endmodule

bind timer8_waveform_mode_control timer8_wmc_checker u_timer8_wmc_checker
(
  .clk(clk),
  .sys_rst(sys_rst),
  .bus_req(bus_req),
  .rd_data(rd_data),
  .ext_clk_pin(ext_clk_pin),
  .port_a(port_a),
  .port_b(port_b),
  .cmp_out_a(cmp_out_a),
  .cmp_out_a_oe_n(cmp_out_a_oe_n),
  .cmp_out_b(cmp_out_b),
  .cmp_out_b_oe_n(cmp_out_b_oe_n),
  .irq(irq)
);
